// >>> hw/background_debug_and_trace.sv
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ns
// What this block does
// [R1] Host holds the debug pin low 128 slowest periods, then speedup pulse.
// [R2] Target waits for high, 16 cycles, drives low 128, pulses high, releases.
// [R3] Host times the 128-cycle low pulse to set its bit rate.
// [R4] Simple breakpoint compares CPU address with a 16-bit match value.
// [R5] Forced mode: any access to that address requests background mode.
// [R6] Tagged mode: opcode fetched there is marked for break at queue end.
// [R7] Breakpoint enable resets to 0; while 0 no simple breakpoint requests.
// [R8] Force-or-tag select: 1 forced, 0 tagged.
// [R9] Eight-entry trace FIFO of address or data, trigger filled, link read.
// [R10] Two 16-bit comparators with R/W ignore, opcode tracking, range compare.
// [R11] Comparators are quiet during every debug-controller bus access.
// [R12] A compares address; B compares address or 8-bit data by mode.
// [R13] Data compare uses write bus if A R/W enabled and set to write.
// [R14] Qualified match breaks, stores data, starts or stops flow tracing.
// [R15] Count shows valid words; manual early stop shifts by one place.
// [R16] Host reads high then low byte; low read shifts the FIFO.
// [R17] Event-only modes store 8-bit data in low half; low read advances.
// [R18] Flow change at start trigger or next two cycles not stored.
// [R19] Unarmed, each low read pushes the last fetched opcode address.
// [R20] Taken conditional branch stores its own address; BRA/BRN nothing.
// [R21] Indirect jumps, calls, interrupts and returns store the destination.
// [R22] Writing arm 1 sets running flag, clears match flags and count.
module background_debug_and_trace
  import dbg_pkg::*;
#(
  parameter int DETECT_CYCLES = SYNC_REQ_PERIODS * SLOW_CLK_DIV
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [31:0]       reg_rdata,
  input  wire logic         cpu_valid,
  input  wire logic [15:0]  cpu_addr,
  input  wire logic         cpu_rw,
  input  wire logic [7:0]   cpu_rdata,
  input  wire logic [7:0]   cpu_wdata,
  input  wire logic         cpu_opcode_fetch,
  input  wire logic         bdc_access,
  input  wire logic         exec_valid,
  input  wire logic [15:0]  exec_addr,
  input  dbg_pkg::cof_kind_type cof_kind,
  input  wire logic [15:0]  cof_src_addr,
  input  wire logic [15:0]  cof_dst_addr,
  input  wire logic         debug_wire_pin_in,
  output logic              debug_wire_pin_out,
  output logic              debug_wire_pin_oe,
  output logic              force_break_req,
  output logic              tag_mark
);
  typedef logic [7:0][15:0] fifo_type;
  typedef struct packed {
    logic        bkpt_en;
    logic        force_or_tag_select;
    logic [15:0] bkpt_addr;
    logic [15:0] comp_a;
    logic [15:0] comp_b;
    logic [15:0] ctrl;
    logic        af;
    logic        bf;
    logic        trace_running_flag;
    logic [3:0]  cnt;
    logic        started;
    logic [1:0]  skip;
    logic        a_seen;
    logic [15:0] last_fetch;
    fifo_type    fifo;
    logic [31:0] rdata;
    logic        force_req;
    logic        tag_req;
  } top_state_type;
  top_state_type st_reg, st_next;

  // [R9] Oldest word sits at index 7 once eight pushes have gone in
  function automatic fifo_type shift_in(fifo_type f, logic [15:0] w);
    return {f[6:0], w};
  endfunction : shift_in

  function automatic logic [3:0] count_up(logic [3:0] c);
    return (c == FIFO_DEPTH) ? FIFO_DEPTH : c + 4'h1;
  endfunction : count_up

  ////////////////////////////////////////////////////////////////////////////
  trig_mode_type mode;
  logic          event_only, full_mode, begin_type, trig;
  logic          trgsel, cmp_valid, cof_store, bp_hit;
  logic [15:0]   cmp_addr, cof_word;
  logic [7:0]    data_sel;
  logic          a_qual, a_hit, a_lt, b_hit, b_gt;

  assign mode       = trig_mode_type'(st_reg.ctrl[CTL_MODE_LSB +: 4]);
  assign event_only = mode == MODE_EVENT_B || mode == MODE_A_THEN_EVENT_B;
  assign full_mode  = mode == MODE_A_AND_DATA || mode == MODE_A_NOT_DATA;
  assign begin_type = st_reg.ctrl[CTL_BEGIN] || event_only;
  // Opcode tracking: match only on executed opcodes
  assign trgsel     = st_reg.ctrl[CTL_TRGSEL];
  assign cmp_addr   = trgsel ? exec_addr : cpu_addr;
  assign cmp_valid  = trgsel ? exec_valid : cpu_valid;
  // [R13] Write bus for write-qualified A
  assign data_sel   = (st_reg.ctrl[CTL_COMP_A_RW_QUALIFY_ENABLE] && !st_reg.ctrl[CTL_RWA]) ? cpu_wdata : cpu_rdata;

  // [R10] Comparator A, address only
  trace_comparator u_comp_a (
    .value    (st_reg.comp_a),
    .addr     (cmp_addr),
    .data     (data_sel),
    .use_data (1'b0),
    .valid    (cmp_valid),
    .suppress (bdc_access),
    .rw       (cpu_rw),
    .rw_en    (st_reg.ctrl[CTL_COMP_A_RW_QUALIFY_ENABLE]),
    .rw_val   (st_reg.ctrl[CTL_RWA]),
    .qual     (a_qual),
    .hit      (a_hit),
    .lt       (a_lt),
    .gt       ()
  );
  // [R12] Comparator B on data in full modes
  trace_comparator u_comp_b (
    .value    (st_reg.comp_b),
    .addr     (cmp_addr),
    .data     (data_sel),
    .use_data (full_mode),
    .valid    (cmp_valid),
    .suppress (bdc_access),
    .rw       (cpu_rw),
    .rw_en    (st_reg.ctrl[CTL_RWBEN] && !full_mode),
    .rw_val   (st_reg.ctrl[CTL_RWB]),
    .qual     (),
    .hit      (b_hit),
    .lt       (),
    .gt       (b_gt)
  );

  always_comb begin
    case (mode)
      MODE_A_ONLY:         trig = a_hit;
      MODE_A_OR_B:         trig = a_hit || b_hit;
      MODE_A_THEN_B:       trig = st_reg.a_seen && b_hit;
      MODE_A_AND_DATA:     trig = a_hit && b_hit;
      MODE_A_NOT_DATA:     trig = a_hit && !b_hit;
      MODE_EVENT_B:        trig = b_hit;
      MODE_A_THEN_EVENT_B: trig = st_reg.a_seen && b_hit;
      MODE_INSIDE:         trig = a_qual && !a_lt && !b_gt;
      MODE_OUTSIDE:        trig = a_lt || b_gt;
      default:             trig = 1'b0;
    endcase
  end

  // [R20] Conditional source; [R21] destinations
  assign cof_store = cof_kind == COF_COND_TAKEN || cof_kind == COF_INDIRECT
                     || cof_kind == COF_INT_RET;
  assign cof_word  = (cof_kind == COF_COND_TAKEN) ? cof_src_addr : cof_dst_addr;
  // [R4] Simple address match
  assign bp_hit    = st_reg.bkpt_en && cpu_valid && cpu_addr == st_reg.bkpt_addr;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next           = st_reg;
    st_next.rdata     = 32'h0000_0000;
    st_next.force_req = 1'b0;
    st_next.tag_req   = 1'b0;
    if (cpu_valid && cpu_opcode_fetch && !bdc_access) st_next.last_fetch = cpu_addr;
    if (reg_wr) begin
      case (reg_addr)
        OFS_STATUS_CONTROL: begin
          st_next.bkpt_en = reg_wdata[BIT_BKPT_EN];
          st_next.force_or_tag_select     = reg_wdata[BIT_FTS];
        end
        OFS_BKPT_ADDR: st_next.bkpt_addr = reg_wdata[15:0];
        OFS_COMP_A:    st_next.comp_a    = reg_wdata[15:0];
        OFS_COMP_B:    st_next.comp_b    = reg_wdata[15:0];
        OFS_TRACE_CTRL: begin
          st_next.ctrl = reg_wdata[15:0];
          // [R22] Arm starts a fresh run
          if (reg_wdata[CTL_ARM]) begin
            st_next.trace_running_flag    = 1'b1;
            st_next.af      = 1'b0;
            st_next.bf      = 1'b0;
            st_next.cnt     = 4'h0;
            st_next.started = 1'b0;
            st_next.a_seen  = 1'b0;
            st_next.skip    = 2'h0;
          end else if (st_reg.trace_running_flag) begin
            // [R15] Early stop shifts by one
            st_next.trace_running_flag = 1'b0;
            if (st_reg.cnt != FIFO_DEPTH) st_next.fifo = shift_in(st_reg.fifo, 16'h0000);
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_STATUS_CONTROL: st_next.rdata = {30'h0, st_reg.force_or_tag_select, st_reg.bkpt_en};
        OFS_BKPT_ADDR:      st_next.rdata = {16'h0000, st_reg.bkpt_addr};
        OFS_COMP_A:         st_next.rdata = {16'h0000, st_reg.comp_a};
        OFS_COMP_B:         st_next.rdata = {16'h0000, st_reg.comp_b};
        OFS_TRACE_CTRL:     st_next.rdata = {16'h0000, st_reg.ctrl};
        OFS_TRACE_STAT:
          st_next.rdata = {24'h0, st_reg.cnt, 1'b0, st_reg.trace_running_flag, st_reg.bf, st_reg.af};
        // [R16] High byte, no side effect
        OFS_FIFO_HIGH:      st_next.rdata = {24'h0, st_reg.fifo[7][15:8]};
        OFS_FIFO_LOW: begin
          st_next.rdata = {24'h0, st_reg.fifo[7][7:0]};
          // [R19] Profiling push when unarmed
          st_next.fifo = shift_in(st_next.fifo, st_reg.trace_running_flag ? 16'h0000 : st_reg.last_fetch);
        end
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    // Flags set after the clear so a same-cycle match survives a re-arm made while already running
    if (st_reg.trace_running_flag) begin
      if (a_hit) st_next.af = 1'b1;
      if (b_hit) st_next.bf = 1'b1;
      if (a_hit) st_next.a_seen = 1'b1;
    end
    // [R14] Trigger actions while running; a control write in the same cycle wins
    if (st_reg.trace_running_flag && st_next.trace_running_flag && !(reg_wr && reg_addr == OFS_TRACE_CTRL)) begin
      if (event_only) begin
        // [R17] Data in low half only
        if (trig) begin
          st_next.fifo = shift_in(st_next.fifo, {8'h00, data_sel});
          st_next.cnt  = count_up(st_reg.cnt);
          if (st_next.cnt == FIFO_DEPTH) st_next.trace_running_flag = 1'b0;
        end
      end else if (begin_type) begin
        if (!st_reg.started) begin
          // [R18] Trigger cycle and two more are lost
          if (trig) begin
            st_next.started = 1'b1;
            st_next.skip    = COF_SKIP_CYCLES;
          end
        end else if (st_reg.skip != 2'h0) begin
          if (cpu_valid) st_next.skip = st_reg.skip - 2'h1;
        end else if (cof_store) begin
          st_next.fifo = shift_in(st_next.fifo, cof_word);
          st_next.cnt  = count_up(st_reg.cnt);
          if (st_next.cnt == FIFO_DEPTH) st_next.trace_running_flag = 1'b0;
        end
      end else begin
        // [R18] End trace keeps the trigger's own flow change
        if (cof_store) begin
          st_next.fifo = shift_in(st_next.fifo, cof_word);
          st_next.cnt  = count_up(st_reg.cnt);
        end
        if (trig) st_next.trace_running_flag = 1'b0;
      end
      // Full modes drop the data match only for tag requests
      if (st_reg.ctrl[CTL_BRK] && ((full_mode && st_reg.ctrl[CTL_TAG]) ? a_hit : trig)) begin
        if (st_reg.ctrl[CTL_TAG]) st_next.tag_req = 1'b1;
        else st_next.force_req = 1'b1;
      end
    end
    // [R7] Enable gates; [R8] select kind
    if (bp_hit) begin
      // [R5] Forced on any access
      if (st_reg.force_or_tag_select) st_next.force_req = 1'b1;
      // [R6] Tag only opcode fetches
      else if (cpu_opcode_fetch) st_next.tag_req = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg           <= '0;
      st_reg.ctrl      <= CTRL_RESET;
      st_reg.bkpt_addr <= ADDR_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata       = st_reg.rdata;
  assign force_break_req = st_reg.force_req;
  assign tag_mark        = st_reg.tag_req;

  // [R2] Speed probe answer on the pin
  sync_probe_responder #(.DETECT_CYCLES(DETECT_CYCLES)) u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin_in  (debug_wire_pin_in),
    .pin_out (debug_wire_pin_out),
    .pin_oe  (debug_wire_pin_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_bkpt_off;
    !st_reg.bkpt_en && !st_reg.ctrl[CTL_BRK] |=> !force_break_req && !tag_mark;
  endproperty
  a_bkpt_off: assert property (p_bkpt_off) else $error("break while disabled"); // [R7]
  property p_force;
    st_reg.bkpt_en && st_reg.force_or_tag_select && bp_hit |=> force_break_req && !tag_mark;
  endproperty
  a_force: assert property (p_force) else $error("forced break missing"); // [R5]
  property p_tag;
    bp_hit && !st_reg.force_or_tag_select && cpu_opcode_fetch && !st_reg.ctrl[CTL_BRK] |=> tag_mark;
  endproperty
  a_tag: assert property (p_tag) else $error("tag mark missing"); // [R8]
  property p_arm;
    reg_wr && reg_addr == OFS_TRACE_CTRL && reg_wdata[CTL_ARM] |=> st_reg.trace_running_flag
      && st_reg.cnt == 4'h0;
  endproperty
  a_arm: assert property (p_arm) else $error("arm did not restart run"); // [R22]
  property p_count;
    st_reg.cnt <= FIFO_DEPTH;
  endproperty
  a_count: assert property (p_count) else $error("count over depth"); // [R15]
  property p_profile;
    reg_rd && reg_addr == OFS_FIFO_LOW && !st_reg.trace_running_flag |=>
      st_reg.fifo[0] == $past(st_reg.last_fetch) && st_reg.fifo[7] == $past(st_reg.fifo[6]);
  endproperty
  a_profile: assert property (p_profile) else $error("profile push wrong"); // [R19]
  property p_event;
    st_reg.trace_running_flag && event_only && trig && !reg_rd && !reg_wr |=>
      st_reg.fifo[0] == {8'h00, $past(data_sel)};
  endproperty
  a_event: assert property (p_event) else $error("event data not stored"); // [R17]
  property p_quiet;
    bdc_access |-> !a_hit && !b_hit && !a_lt && !b_gt;
  endproperty
  a_quiet: assert property (p_quiet) else $error("compare during debug access"); // [R11]
  property p_skip;
    st_reg.trace_running_flag && st_reg.started && st_reg.skip != 2'h0 && !event_only && !reg_wr |=>
      st_reg.cnt == $past(st_reg.cnt);
  endproperty
  a_skip: assert property (p_skip) else $error("flow stored in blind cycles"); // [R18]
  c_full: cover property (st_reg.cnt == FIFO_DEPTH && !st_reg.trace_running_flag);
  c_force: cover property (force_break_req);
  c_profile: cover property (reg_rd && reg_addr == OFS_FIFO_LOW && !st_reg.trace_running_flag);
endmodule : background_debug_and_trace

// >>> hw/dbg_pkg.sv
package dbg_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_BKPT_ADDR      = 8'h04;
  localparam logic [7:0] OFS_COMP_A         = 8'h08;
  localparam logic [7:0] OFS_COMP_B         = 8'h0c;
  localparam logic [7:0] OFS_TRACE_CTRL     = 8'h10;
  localparam logic [7:0] OFS_TRACE_STAT     = 8'h14;
  localparam logic [7:0] OFS_FIFO_HIGH      = 8'h18;
  localparam logic [7:0] OFS_FIFO_LOW       = 8'h1c;
  // debug_status_control fields
  localparam int BIT_BKPT_EN = 0;
  localparam int BIT_FTS     = 1;
  // trace_control_reg fields
  localparam int CTL_ARM      = 0;
  localparam int CTL_BRK      = 1;
  localparam int CTL_TAG      = 2;
  localparam int CTL_COMP_A_RW_QUALIFY_ENABLE    = 3;
  localparam int CTL_RWA      = 4;
  localparam int CTL_RWBEN    = 5;
  localparam int CTL_RWB      = 6;
  localparam int CTL_BEGIN    = 7;
  localparam int CTL_TRGSEL   = 8;
  localparam int CTL_MODE_LSB = 12;
  // trace_status_reg fields
  localparam int STAT_AF      = 0;
  localparam int STAT_BF      = 1;
  localparam int STAT_TRACE_RUNNING_FLAG    = 2;
  localparam int STAT_CNT_LSB = 4;
  // Reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  // Trace FIFO and pipeline
  localparam logic [3:0] FIFO_DEPTH      = 4'h8;
  localparam logic [1:0] COF_SKIP_CYCLES = 2'h2;
  // Speed probe timing, in debug clock cycles
  localparam int SYNC_REQ_PERIODS  = 128;
  localparam int SLOW_CLK_DIV      = 64;
  localparam int SYNC_DELAY_CYCLES = 16;
  localparam int SYNC_LOW_CYCLES   = 128;
  typedef enum logic [3:0] {
    MODE_A_ONLY, MODE_A_OR_B, MODE_A_THEN_B, MODE_A_AND_DATA, MODE_A_NOT_DATA,
    MODE_EVENT_B, MODE_A_THEN_EVENT_B, MODE_INSIDE, MODE_OUTSIDE
  } trig_mode_type;
  typedef enum logic [2:0] {
    COF_NONE, COF_COND_TAKEN, COF_BRA_BRN, COF_INDIRECT, COF_INT_RET
  } cof_kind_type;
endpackage : dbg_pkg

// >>> hw/trace_comparator.sv
`timescale 1ns/1ns
module trace_comparator (
  input  wire logic [15:0] value,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  data,
  input  wire logic        use_data,
  input  wire logic        valid,
  input  wire logic        suppress,
  input  wire logic        rw,
  input  wire logic        rw_en,
  input  wire logic        rw_val,
  output logic             qual,
  output logic             hit,
  output logic             lt,
  output logic             gt
);
  always_comb begin
    // [R11] Quiet during debug-controller accesses
    qual = valid && !suppress && (!rw_en || rw == rw_val);
    hit  = qual && (use_data ? data == value[7:0] : addr == value);
    lt   = qual && addr < value;
    gt   = qual && addr > value;
  end
endmodule : trace_comparator

// >>> hw/sync_probe_responder.sv
`timescale 1ns/1ns
module sync_probe_responder
  import dbg_pkg::*;
#(
  parameter int DETECT_CYCLES = SYNC_REQ_PERIODS * SLOW_CLK_DIV
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe
);
  typedef enum logic [2:0] {PH_IDLE, PH_WAIT_HIGH, PH_DELAY, PH_LOW, PH_SPEEDUP} phase_type;
  typedef struct packed {
    phase_type   phase;
    logic [13:0] count;
    logic        out;
    logic        oe;
  } sync_state_type;
  sync_state_type st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.count = st_reg.count + 14'h0001;
    case (st_reg.phase)
      PH_IDLE: begin
        // Long low only counts while we are not driving
        if (pin_in) st_next.count = 14'h0000;
        else if (st_reg.count == 14'(DETECT_CYCLES - 1)) st_next.phase = PH_WAIT_HIGH;
      end
      PH_WAIT_HIGH: begin
        st_next.count = 14'h0000;
        if (pin_in) st_next.phase = PH_DELAY;
      end
      // [R2] Delay then low pulse
      PH_DELAY: begin
        if (st_reg.count == 14'(SYNC_DELAY_CYCLES - 1)) begin
          st_next = '{PH_LOW, 14'h0000, 1'b0, 1'b1};
        end
      end
      PH_LOW: begin
        if (st_reg.count == 14'(SYNC_LOW_CYCLES - 1)) st_next.phase = PH_SPEEDUP;
        if (st_reg.count == 14'(SYNC_LOW_CYCLES - 1)) st_next.out = 1'b1;
      end
      PH_SPEEDUP: st_next = '{PH_IDLE, 14'h0000, 1'b0, 1'b0};
      default: st_next = '{PH_IDLE, 14'h0000, 1'b0, 1'b0};
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) st_reg <= '{PH_IDLE, 14'h0000, 1'b0, 1'b0};
    else st_reg <= st_next;
  end
  assign pin_out = st_reg.out;
  assign pin_oe  = st_reg.oe;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_sync_pulse;
    $rose(pin_oe) |-> ##128 (pin_oe && pin_out) ##1 !pin_oe;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse length wrong"); // [R2]
  property p_sync_low;
    $rose(pin_oe) |-> (!pin_out)[*8];
  endproperty
  a_sync_low: assert property (p_sync_low) else $error("sync pulse not low"); // [R2]
  c_sync: cover property ($fell(pin_oe));
endmodule : sync_probe_responder

// >>> testbench/sync_host.sv
`timescale 1ns/1ns
module sync_host #(
  parameter int REQ_CYCLES = 30
) (
  input  wire logic ref_clk,
  input  wire logic start,
  input  wire logic pin,
  output logic      host_oe,
  output logic      host_out,
  output int        low_len,
  output int        gap_len,
  output logic      done
);
  int n;
  initial begin
    host_oe = 1'b0;
    host_out = 1'b1;
    done = 1'b0;
  end
  always begin
    wait (start);
    @(posedge ref_clk);
    host_oe <= 1'b1;
    host_out <= 1'b0;
    repeat (REQ_CYCLES) @(posedge ref_clk);
    host_out <= 1'b1;
    @(posedge ref_clk);
    host_oe <= 1'b0;
    gap_len = 0;
    low_len = 0;
    n = 0;
    while (pin === 1'b1 && n < 400) begin
      @(posedge ref_clk);
      gap_len++;
      n++;
    end
    while (pin === 1'b0 && n < 400) begin
      @(posedge ref_clk);
      low_len++;
      n++;
    end
    done <= 1'b1;
    wait (!start);
    done <= 1'b0;
  end
endmodule : sync_host

// >>> testbench/tb.sv
`timescale 1ns/1ns
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t: got %h want %h", $time, g, e); end end
module tb;
  import dbg_pkg::*;
  logic         ref_clk   = 1'b0;
  logic         rst_b     = 1'b0;
  logic [7:0]   reg_addr  = 8'h00;
  logic [31:0]  reg_wdata = 32'h0;
  logic         reg_wr    = 1'b0;
  logic         reg_rd    = 1'b0;
  logic [31:0]  reg_rdata;
  logic [31:0]  rd_val;
  logic         cpu_valid = 1'b0;
  logic [15:0]  cpu_addr  = 16'h0;
  logic         cpu_rw    = 1'b1;
  logic [7:0]   cpu_rdata = 8'h0;
  logic [7:0]   cpu_wdata = 8'h0;
  logic         fetch     = 1'b0;
  logic         bdc       = 1'b0;
  logic         exec_on   = 1'b0;
  cof_kind_type cof_kind  = COF_NONE;
  logic [15:0]  cof_src   = 16'h0;
  logic [15:0]  cof_dst   = 16'h0;
  logic         pin_out, pin_oe, fbr, tag, fbr_s, tag_s;
  logic         start     = 1'b0;
  logic         host_oe, host_out, done;
  int           low_len, gap_len;
  int           bad_count = 0;
  int           tests_run = 0;
  // Pull-up holds the wire high when nobody drives
  wire          pin = pin_oe ? pin_out : (host_oe ? host_out : 1'b1);
  always #4 ref_clk = ~ref_clk;
  background_debug_and_trace #(.DETECT_CYCLES(20)) uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_valid(cpu_valid),
    .cpu_addr(cpu_addr), .cpu_rw(cpu_rw), .cpu_rdata(cpu_rdata), .cpu_wdata(cpu_wdata),
    .cpu_opcode_fetch(fetch), .bdc_access(bdc), .exec_valid(cpu_valid && exec_on),
    .exec_addr(cpu_addr), .cof_kind(cof_kind), .cof_src_addr(cof_src), .cof_dst_addr(cof_dst),
    .debug_wire_pin_in(pin), .debug_wire_pin_out(pin_out), .debug_wire_pin_oe(pin_oe),
    .force_break_req(fbr), .tag_mark(tag));
  sync_host #(.REQ_CYCLES(30)) host (
    .ref_clk(ref_clk), .start(start), .pin(pin), .host_oe(host_oe),
    .host_out(host_out), .low_len(low_len), .gap_len(gap_len), .done(done));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Data stands one cycle only, so sample mid-cycle
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd_val = reg_rdata;
  endtask : rd
  task automatic bus(input logic [15:0] a, input logic [7:0] r, input logic [7:0] w,
                     input logic rw, input logic f, input logic b);
    @(posedge ref_clk);
    cpu_valid <= 1'b1;
    cpu_addr <= a;
    cpu_rdata <= r;
    cpu_wdata <= w;
    cpu_rw <= rw;
    fetch <= f;
    bdc <= b;
    @(posedge ref_clk);
    cpu_valid <= 1'b0;
    fetch <= 1'b0;
    bdc <= 1'b0;
    @(negedge ref_clk);
    fbr_s = fbr;
    tag_s = tag;
  endtask : bus
  task automatic cof(input cof_kind_type k, input logic [15:0] s, input logic [15:0] d);
    @(posedge ref_clk);
    cof_kind <= k;
    cof_src <= s;
    cof_dst <= d;
    @(posedge ref_clk);
    cof_kind <= COF_NONE;
  endtask : cof
  task automatic probe(input logic [31:0] c, input logic [15:0] a, input logic [7:0] r,
                       input logic [7:0] w, input logic b, input logic e);
    wr(OFS_TRACE_CTRL, c);
    bus(a, r, w, 1'b0, 1'b0, b);
    `CHECK(fbr_s, e)
  endtask : probe
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(OFS_STATUS_CONTROL);
    `CHECK(rd_val, 32'h0)
    rd(OFS_TRACE_STAT);
    `CHECK(rd_val, 32'h0)
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40);
    `CHECK(rd_val, 32'h0)
  endtask : t_reset
  task automatic t_sync;
    @(posedge ref_clk);
    start <= 1'b1;
    for (int i = 0; i < 600 && done !== 1'b1; i++) @(posedge ref_clk);
    `CHECK(low_len, 128)
    `CHECK(gap_len >= 16 && gap_len <= 20, 1'b1)
    `CHECK(pin_oe, 1'b0)
    start <= 1'b0;
  endtask : t_sync
  task automatic t_bkpt;
    wr(OFS_BKPT_ADDR, 32'h1234);
    bus(16'h1234, 8'h0, 8'h0, 1'b1, 1'b1, 1'b0);
    `CHECK({fbr_s, tag_s}, 2'b00)
    wr(OFS_STATUS_CONTROL, 32'h3);
    bus(16'h1234, 8'h0, 8'h0, 1'b1, 1'b0, 1'b0);
    `CHECK({fbr_s, tag_s}, 2'b10)
    bus(16'h1235, 8'h0, 8'h0, 1'b1, 1'b0, 1'b0);
    `CHECK(fbr_s, 1'b0)
    wr(OFS_STATUS_CONTROL, 32'h1);
    bus(16'h1234, 8'h0, 8'h0, 1'b1, 1'b1, 1'b0);
    `CHECK({fbr_s, tag_s}, 2'b01)
    wr(OFS_STATUS_CONTROL, 32'h0);
  endtask : t_bkpt
  task automatic t_comp;
    wr(OFS_COMP_A, 32'h2000);
    wr(OFS_COMP_B, 32'h005a);
    probe(32'h0003, 16'h2000, 8'h0, 8'h0, 1'b1, 1'b0);
    probe(32'h0003, 16'h2000, 8'h0, 8'h0, 1'b0, 1'b1);
    probe(32'h0007, 16'h2000, 8'h0, 8'h0, 1'b0, 1'b0);
    `CHECK(tag_s, 1'b1)
    probe(32'h1003, 16'h005a, 8'h0, 8'h0, 1'b0, 1'b1);
    probe(32'h2003, 16'h2000, 8'h0, 8'h0, 1'b0, 1'b0);
    bus(16'h005a, 8'h0, 8'h0, 1'b0, 1'b0, 1'b0);
    `CHECK(fbr_s, 1'b1)
    probe(32'h300b, 16'h2000, 8'h00, 8'h5a, 1'b0, 1'b1);
    probe(32'h300b, 16'h2000, 8'h5a, 8'h00, 1'b0, 1'b0);
    probe(32'h400b, 16'h2000, 8'h5a, 8'h00, 1'b0, 1'b1);
    probe(32'h0103, 16'h2000, 8'h0, 8'h0, 1'b0, 1'b0);
    @(posedge ref_clk);
    exec_on <= 1'b1;
    probe(32'h0103, 16'h2000, 8'h0, 8'h0, 1'b0, 1'b1);
    @(posedge ref_clk);
    exec_on <= 1'b0;
    wr(OFS_COMP_A, 32'h0100);
    wr(OFS_COMP_B, 32'h01ff);
    probe(32'h7003, 16'h01ff, 8'h0, 8'h0, 1'b0, 1'b1);
    probe(32'h7003, 16'h0200, 8'h0, 8'h0, 1'b0, 1'b0);
    probe(32'h8003, 16'h0200, 8'h0, 8'h0, 1'b0, 1'b1);
    probe(32'h8003, 16'h0150, 8'h0, 8'h0, 1'b0, 1'b0);
  endtask : t_comp
  task automatic t_event;
    wr(OFS_COMP_B, 32'h3000);
    wr(OFS_TRACE_CTRL, 32'h5001);
    for (int i = 0; i < 8; i++) bus(16'h3000, 8'h10 + 8'(i), 8'h10 + 8'(i), 1'b1, 1'b0, 1'b0);
    rd(OFS_TRACE_STAT);
    `CHECK(rd_val[7:0], 8'h82)
    for (int i = 0; i < 8; i++) begin
      rd(OFS_FIFO_LOW);
      `CHECK(rd_val[7:0], 8'h10 + 8'(i))
    end
  endtask : t_event
  task automatic t_flow;
    logic [15:0] exp [3];
    exp = '{16'h1111, 16'h2222, 16'h3333};
    wr(OFS_COMP_A, 32'hfff0);
    wr(OFS_TRACE_CTRL, 32'h0001);
    rd(OFS_TRACE_STAT);
    `CHECK(rd_val, 32'h4)
    cof(COF_COND_TAKEN, 16'h1111, 16'haaaa);
    cof(COF_BRA_BRN, 16'h5555, 16'h6666);
    cof(COF_INDIRECT, 16'h7777, 16'h2222);
    cof(COF_INT_RET, 16'h8888, 16'h3333);
    wr(OFS_TRACE_CTRL, 32'h0000);
    rd(OFS_TRACE_STAT);
    `CHECK(rd_val, 32'h30)
    // Early stop: (8 - 3) - 1 dummy reads
    repeat (4) rd(OFS_FIFO_LOW);
    for (int i = 0; i < 3; i++) begin
      rd(OFS_FIFO_HIGH);
      `CHECK(rd_val[7:0], exp[i][15:8])
      rd(OFS_FIFO_LOW);
      `CHECK(rd_val[7:0], exp[i][7:0])
    end
  endtask : t_flow
  task automatic t_profile;
    bus(16'h4567, 8'h0, 8'h0, 1'b1, 1'b1, 1'b0);
    repeat (8) rd(OFS_FIFO_LOW);
    rd(OFS_FIFO_HIGH);
    `CHECK(rd_val[7:0], 8'h45)
    rd(OFS_FIFO_LOW);
    `CHECK(rd_val[7:0], 8'h67)
  endtask : t_profile
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Checks %0d, errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  // Whole run is a few hundred cycles
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_sync();
    t_bkpt();
    t_comp();
    t_event();
    t_flow();
    t_profile();
    print_verdict();
  end
endmodule : tb
